// file: design/pwm_edge_timing_control.sv
/*
 * Edge placement for the first and second PWM outputs, with an Avalon-MM
 * register slave. Assumes a synchronous modulation word from the loop
 * filter and a master that holds each request until waitrequest is low.
 */
// Function
// - First rise time: coarse byte high, setting bits 7:4 low, 5 ns each.
// - First fall time: coarse byte high, setting top nibble low, 5 ns.
// - Second rise time: coarse byte high, setting top nibble low, 5 ns.
// - First rise setting bit 3 enables modulation of that rise edge.
// - First fall setting bit 3 enables modulation of the fall edge.
// - Sign bit set: larger modulation moves the edge later.
// - Sign bit clear: larger modulation moves the edge earlier.
`timescale 1ns/1ps

module pwm_edge_timing_control #(
	parameter int MOD_W = 12
) (
	input  wire logic             clk_in,
	input  wire logic             nrst_in,
	input  wire logic [8:0]       address_in,
	input  wire logic             read_in,
	input  wire logic             write_in,
	input  wire logic [3:0]       byteenable_in,
	input  wire logic [31:0]      writedata_in,
	output logic      [31:0]      readdata_out,
	output logic                  waitrequest_out,
	input  wire logic [MOD_W-1:0] mod_value_in,
	output logic                  pwm_out_first_out,
	output logic                  pwm_out_second_out
);

	// Refused at elaboration: the offset arithmetic is only EW+2 bits wide
	if (MOD_W < 1 || MOD_W > pwm_edge_pkg::EDGE_W) begin
		$error("MOD_W must lie in 1..12");
	end
	if (pwm_edge_pkg::CLK_PERIOD_NS % pwm_edge_pkg::TIME_STEP_NS != 0) begin
		$error("Clock period must be a multiple of the edge step");
	end

	localparam int EW = pwm_edge_pkg::EDGE_W;
	localparam int CW = pwm_edge_pkg::CNT_W;
	localparam logic [CW-1:0] STEP = CW'(pwm_edge_pkg::CNT_STEP);

	// Register storage
	pwm_edge_pkg::edge_cfg_t a_rise_q;
	pwm_edge_pkg::edge_cfg_t a_fall_q;
	pwm_edge_pkg::edge_cfg_t b_rise_q;
	logic [EW-1:0]           period_q;
	logic                    run_q;

	// Timing state
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic [EW-1:0] first_rise_time_q;
	logic [EW-1:0] first_fall_time_q;
	logic [EW-1:0] second_rise_time_q;
	logic          first_q;
	logic          second_q;

	// Bus handshake state
	logic        ack_q;
	logic [31:0] rdata_q;

	// Signed modulation offset, optionally inverted, then clamped to range
	function automatic logic [EW-1:0] edge_time(
		input pwm_edge_pkg::edge_cfg_t cfg,
		input logic [MOD_W-1:0]        mod
	);
		logic signed [EW+1:0] base;
		logic signed [EW+1:0] off;
		logic signed [EW+1:0] sum;
		base = $signed({2'b00, cfg.coarse, cfg.setting.fine});
		off  = (EW+2)'($signed(mod));
		if (!cfg.setting.mod_en)
			off = '0;
		else if (!cfg.setting.sign)
			off = -off;
		sum = base + off;
		if (sum < 0)
			edge_time = '0;
		else if (sum > $signed({2'b00, {EW{1'b1}}}))
			edge_time = {EW{1'b1}};
		else
			edge_time = sum[EW-1:0];
	endfunction

	// Address decode
	wire        req       = read_in | write_in;
	wire        take      = req & ~ack_q;
	wire [6:0]  idx       = address_in[8:2];
	wire        aligned   = address_in[1:0] == 2'b00;
	wire        sel_ar_c  = aligned & (idx == pwm_edge_pkg::IDX_A_RISE_COARSE);
	wire        sel_ar_f  = aligned & (idx == pwm_edge_pkg::IDX_A_RISE_FINE);
	wire        sel_af_c  = aligned & (idx == pwm_edge_pkg::IDX_A_FALL_COARSE);
	wire        sel_af_f  = aligned & (idx == pwm_edge_pkg::IDX_A_FALL_FINE);
	wire        sel_br_c  = aligned & (idx == pwm_edge_pkg::IDX_B_RISE_COARSE);
	wire        sel_br_f  = aligned & (idx == pwm_edge_pkg::IDX_B_RISE_FINE);
	wire        sel_ctrl  = aligned & (idx == pwm_edge_pkg::IDX_CTRL);
	wire        sel_stat  = aligned & (idx == pwm_edge_pkg::IDX_STATUS);
	// Writes land at the edge where the master sees waitrequest low
	wire        wr_go     = write_in & ack_q;
	wire        wr_b0     = wr_go & byteenable_in[0];
	wire [7:0]  wbyte     = writedata_in[7:0];

	// Reserved setting bits are stored and read back as written
	wire [31:0] ctrl_word = 32'(period_q) << pwm_edge_pkg::CTRL_PERIOD_LSB |
		32'(run_q) << pwm_edge_pkg::CTRL_RUN_BIT;
	wire [31:0] stat_word = 32'(cnt_q) << pwm_edge_pkg::STAT_CNT_LSB |
		32'(first_q) << pwm_edge_pkg::STAT_FIRST_BIT |
		32'(second_q) << pwm_edge_pkg::STAT_SECOND_BIT;

	logic [31:0] rd_mux;
	always_comb begin
		if (sel_ar_c)
			rd_mux = {24'h00_0000, a_rise_q.coarse};
		else if (sel_ar_f)
			rd_mux = {24'h00_0000, a_rise_q.setting};
		else if (sel_af_c)
			rd_mux = {24'h00_0000, a_fall_q.coarse};
		else if (sel_af_f)
			rd_mux = {24'h00_0000, a_fall_q.setting};
		else if (sel_br_c)
			rd_mux = {24'h00_0000, b_rise_q.coarse};
		else if (sel_br_f)
			rd_mux = {24'h00_0000, b_rise_q.setting};
		else if (sel_ctrl)
			rd_mux = ctrl_word;
		else if (sel_stat)
			rd_mux = stat_word;
		else
			rd_mux = 32'h0000_0000;
	end

	// One wait cycle per access; the answer lands on the following edge
	assign waitrequest_out = req & ~ack_q;
	assign readdata_out    = rdata_q;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q <= take;
			if (read_in & take)
				rdata_q <= rd_mux;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			a_rise_q <= {pwm_edge_pkg::COARSE_RESET, pwm_edge_pkg::FINE_RESET};
			a_fall_q <= {pwm_edge_pkg::COARSE_RESET, pwm_edge_pkg::FINE_RESET};
			b_rise_q <= {pwm_edge_pkg::COARSE_RESET, pwm_edge_pkg::FINE_RESET};
		end else begin
			if (wr_b0 & sel_ar_c)
				a_rise_q.coarse <= wbyte;
			if (wr_b0 & sel_ar_f)
				a_rise_q.setting <= wbyte;
			if (wr_b0 & sel_af_c)
				a_fall_q.coarse <= wbyte;
			if (wr_b0 & sel_af_f)
				a_fall_q.setting <= wbyte;
			if (wr_b0 & sel_br_c)
				b_rise_q.coarse <= wbyte;
			if (wr_b0 & sel_br_f)
				b_rise_q.setting <= wbyte;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			period_q <= pwm_edge_pkg::PERIOD_RESET;
			run_q    <= pwm_edge_pkg::RUN_RESET;
		end else begin
			if (wr_go & sel_ctrl & byteenable_in[0])
				period_q[7:0] <= writedata_in[7:0];
			if (wr_go & sel_ctrl & byteenable_in[1])
				period_q[EW-1:8] <= writedata_in[EW-1:8];
			if (wr_go & sel_ctrl & byteenable_in[2])
				run_q <= writedata_in[pwm_edge_pkg::CTRL_RUN_BIT];
		end
	end

	// Period counter in 5 ns units, advancing one clock's worth per cycle
	wire [CW-1:0] cnt_next  = cnt_q + STEP;
	wire          wrap      = cnt_next >= {1'b0, period_q};
	// Tracked while stopped, so the first period never uses stale times
	wire          start     = !run_q | wrap;

	always_comb begin
		if (!run_q)
			cnt_d = '0;
		else if (wrap)
			cnt_d = '0;
		else
			cnt_d = cnt_next;
	end

	// An edge fires in the cycle whose 10 ns window contains it
	wire hit_a_rise = {1'b0, first_rise_time_q} >= cnt_q &&
		{1'b0, first_rise_time_q} < cnt_next;
	wire hit_a_fall = {1'b0, first_fall_time_q} >= cnt_q &&
		{1'b0, first_fall_time_q} < cnt_next;
	wire hit_b_rise = {1'b0, second_rise_time_q} >= cnt_q &&
		{1'b0, second_rise_time_q} < cnt_next;

	// Edge times sampled once per period, so a mid-period write never glitches
	wire [EW-1:0] a_rise_eff = edge_time(a_rise_q, mod_value_in);
	wire [EW-1:0] a_fall_eff = edge_time(a_fall_q, mod_value_in);
	wire [EW-1:0] b_rise_eff = edge_time(b_rise_q, mod_value_in);

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cnt_q              <= '0;
			first_rise_time_q  <= '0;
			first_fall_time_q  <= '0;
			second_rise_time_q <= '0;
		end else begin
			cnt_q <= cnt_d;
			if (start) begin
				first_rise_time_q  <= a_rise_eff;
				first_fall_time_q  <= a_fall_eff;
				second_rise_time_q <= b_rise_eff;
			end
		end
	end

	// Falling edge wins when both land in one cycle; second ends at wrap
	wire first_d  = !run_q ? 1'b0 : hit_a_fall ? 1'b0 :
		hit_a_rise ? 1'b1 : first_q;
	wire second_d = !run_q ? 1'b0 : wrap ? 1'b0 :
		hit_b_rise ? 1'b1 : second_q;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			first_q  <= 1'b0;
			second_q <= 1'b0;
		end else begin
			first_q  <= first_d;
			second_q <= second_d;
		end
	end

	assign pwm_out_first_out  = first_q;
	assign pwm_out_second_out = second_q;

endmodule

// file: inc/pwm_edge_pkg.sv
/*
 * Shared constants and types for the PWM edge timing block: register
 * indices, field layout of the edge setting bytes, reset values, timing.
 * Assumes a 100 MHz system clock and 32-bit Avalon-MM register access.
 */
package pwm_edge_pkg;

	// Register indices; byte address is four times the index
	localparam logic [6:0] IDX_A_RISE_COARSE = 7'h41;
	localparam logic [6:0] IDX_A_RISE_FINE   = 7'h42;
	localparam logic [6:0] IDX_A_FALL_COARSE = 7'h43;
	localparam logic [6:0] IDX_A_FALL_FINE   = 7'h44;
	localparam logic [6:0] IDX_B_RISE_COARSE = 7'h45;
	localparam logic [6:0] IDX_B_RISE_FINE   = 7'h46;
	localparam logic [6:0] IDX_CTRL          = 7'h50;
	localparam logic [6:0] IDX_STATUS        = 7'h51;

	// Control word fields
	localparam int CTRL_PERIOD_LSB = 0;
	localparam int CTRL_RUN_BIT    = 16;
	// Status word fields
	localparam int STAT_CNT_LSB    = 0;
	localparam int STAT_FIRST_BIT  = 16;
	localparam int STAT_SECOND_BIT = 17;

	// Reset values
	localparam logic [7:0]  COARSE_RESET = 8'h00;
	localparam logic [7:0]  FINE_RESET   = 8'h00;
	localparam logic [11:0] PERIOD_RESET = 12'h07D0;
	localparam logic        RUN_RESET    = 1'b0;

	// Timing: one edge count is 5 ns, clock period 10 ns
	localparam int TIME_STEP_NS  = 5;
	localparam int CLK_PERIOD_NS = 10;
	localparam int CNT_STEP      = CLK_PERIOD_NS / TIME_STEP_NS;

	localparam int EDGE_W = 12;
	localparam int CNT_W  = 13;

	// Layout of an edge setting byte, msb first
	typedef struct packed {
		logic [3:0] fine;
		logic       mod_en;
		logic       sign;
		logic [1:0] rsvd;
	} edge_setting_t;

	// One edge: coarse byte and its setting byte
	typedef struct packed {
		logic [7:0]    coarse;
		edge_setting_t setting;
	} edge_cfg_t;

endpackage

// file: verif/pwm_driver_model.sv
/* Switch driver model: stamps the cycle of each first-output edge and each second-output rise it sees.
   Assumes registered PWM levels on the module clock. */
`timescale 1ns/1ps
module pwm_driver_model (
	input  wire logic clk_in,
	input  wire logic nrst_in,
	input  wire logic first_in,
	input  wire logic second_in,
	output int        first_rise_out,
	output int        first_fall_out,
	output int        second_rise_out
);
	int   cyc_q;
	logic first_q;
	logic second_q;
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cyc_q <= 0;
			first_q <= 1'b0;
			second_q <= 1'b0;
			first_rise_out <= 0;
			first_fall_out <= 0;
			second_rise_out <= 0;
		end else begin
			cyc_q <= cyc_q + 1;
			first_q <= first_in;
			second_q <= second_in;
			if (first_in && !first_q) first_rise_out <= cyc_q;
			if (!first_in && first_q) first_fall_out <= cyc_q;
			if (second_in && !second_q) second_rise_out <= cyc_q;
		end
	end
endmodule

// file: verif/pwm_edge_timing_control_properties.sv
/* Checker: bus handshake, status read-back and output gating.
   Assumes the top module's port names. */
`timescale 1ns/1ps
module pwm_edge_props (
	input wire logic        clk_in,
	input wire logic        nrst_in,
	input wire logic [8:0]  address_in,
	input wire logic        read_in,
	input wire logic        write_in,
	input wire logic [3:0]  byteenable_in,
	input wire logic [31:0] writedata_in,
	input wire logic [31:0] readdata_out,
	input wire logic        waitrequest_out,
	input wire logic        pwm_out_first_out,
	input wire logic        pwm_out_second_out
);
	logic run_q;
	wire  req = read_in | write_in;
	wire  ans = read_in & ~waitrequest_out;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	wire [8:0] ctrl_addr = {pwm_edge_pkg::IDX_CTRL, 2'b00};
	wire [8:0] stat_addr = {pwm_edge_pkg::IDX_STATUS, 2'b00};
	// Run bit mirrored from control writes, landing when the wait ends
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			run_q <= 1'b0;
		end else if (write_in && !waitrequest_out && byteenable_in[2]
		    && address_in == ctrl_addr) begin
			run_q <= writedata_in[pwm_edge_pkg::CTRL_RUN_BIT];
		end
	end
	sequence req_start; req && waitrequest_out; endsequence
	sequence stopped; !run_q [*2]; endsequence
	wait_once_a: assert property (req_start |=> !waitrequest_out)
		else $error("wait longer than one cycle");
	wait_first_a: assert property (req && !$past(req) |-> waitrequest_out)
		else $error("no wait in first cycle");
	unmapped_zero_a: assert property (ans && address_in > stat_addr
		|-> readdata_out == 32'h0000_0000) else $error("unmapped read");
	stop_low_a: assert property (stopped
		|-> !pwm_out_first_out && !pwm_out_second_out) else $error("stop");
	first_gate_a: assert property ($rose(pwm_out_first_out)
		|-> $past(run_q)) else $error("first rose while stopped");
	second_gate_a: assert property ($rose(pwm_out_second_out)
		|-> $past(run_q)) else $error("second rose while stopped");
	status_first_a: assert property (ans && address_in == stat_addr
		|-> readdata_out[16] == $past(pwm_out_first_out))
		else $error("status first");
	status_second_a: assert property (ans && address_in == stat_addr
		|-> readdata_out[17] == $past(pwm_out_second_out))
		else $error("status second");
endmodule
bind pwm_edge_timing_control pwm_edge_props u_pwm_edge_props (.*);

// file: verif/pwm_edge_timing_control_test.sv
/* Bench: register access over Avalon-MM and edge placement checks.
   Assumes the block's port names; runs with a period of 40 counts. */
`timescale 1ns/1ps
module pwm_edge_timing_control_test;
	logic        clk_in = 1'b0, nrst_in = 1'b0, read_in = 1'b0;
	logic        write_in = 1'b0;
	logic [8:0]  address_in = 9'h000;
	logic [3:0]  byteenable_in = 4'hf;
	logic [31:0] writedata_in = 32'h0000_0000, readdata_out, rd;
	logic [11:0] mod_value_in = 12'h000;
	logic        waitrequest_out, first_out, second_out;
	int          num_errors = 0, check_count = 0, cycles = 0, fr, ff, sr;
	// Reserved bits 1:0 always written as 00
	logic [7:0]  rise_set [5] = '{8'h40, 8'h4C, 8'h48, 8'h40, 8'h40};
	logic [7:0]  fall_set [5] = '{8'hE0, 8'hE0, 8'hE0, 8'hEC, 8'hE8};
	// Edge at count t fires in cycle t/2; modulation is 4 counts
	int          exp_hi [5] = '{5, 3, 7, 7, 3};
	int          exp_gap [5] = '{5, 7, 3, 5, 5};
	pwm_edge_timing_control u_pwm_edge_timing_control (.clk_in(clk_in),
		.nrst_in(nrst_in), .address_in(address_in), .read_in(read_in),
		.write_in(write_in), .byteenable_in(byteenable_in),
		.writedata_in(writedata_in), .readdata_out(readdata_out),
		.waitrequest_out(waitrequest_out), .mod_value_in(mod_value_in),
		.pwm_out_first_out(first_out), .pwm_out_second_out(second_out));
	pwm_driver_model u_pwm_driver_model (.clk_in(clk_in), .nrst_in(nrst_in),
		.first_in(first_out), .second_in(second_out),
		.first_rise_out(fr), .first_fall_out(ff), .second_rise_out(sr));
	always #5 clk_in = ~clk_in;
	task automatic close_out();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Hang guard: whole run needs under 600 cycles
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			close_out();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [8:0] a,
	    input logic [31:0] d, input logic [3:0] be);
		address_in <= a;
		writedata_in <= d;
		byteenable_in <= be;
		read_in <= !w;
		write_in <= w;
		do @(posedge clk_in); while (waitrequest_out !== 1'b0);
		rd = readdata_out;
		read_in <= 1'b0;
		write_in <= 1'b0;
		@(posedge clk_in);
	endtask
	initial begin
		repeat (20) @(posedge clk_in);
		nrst_in <= 1'b1;
		@(posedge clk_in);
		for (int i = 0; i < 6; i++) begin
			bus(0, 9'h104 + 9'(4 * i), 32'h0000_0000, 4'hf);
			chk("reset value", rd, 32'h0000_0000);
		end
		bus(0, 9'h140, 32'h0000_0000, 4'hf);
		chk("reset control", rd, 32'(pwm_edge_pkg::PERIOD_RESET));
		bus(1, 9'h1FC, 32'h0000_00FF, 4'hf);
		bus(0, 9'h1FC, 32'h0000_0000, 4'hf);
		chk("unmapped", rd, 32'h0000_0000);
		bus(1, 9'h104, 32'h0000_0055, 4'he);
		bus(0, 9'h104, 32'h0000_0000, 4'hf);
		chk("lane gate", rd, 32'h0000_0000);
		$display("register test done");
		// Coarse 1 puts both first-output edges at 16 plus fine counts
		bus(1, 9'h104, 32'h0000_0001, 4'hf);
		bus(1, 9'h10C, 32'h0000_0001, 4'hf);
		bus(1, 9'h118, 32'h0000_00A0, 4'hf);
		bus(0, 9'h118, 32'h0000_0000, 4'hf);
		chk("second setting", rd, 32'h0000_00A0);
		mod_value_in <= 12'h004;
		bus(1, 9'h140, 32'h0001_0028, 4'hf);
		bus(0, 9'h140, 32'h0000_0000, 4'hf);
		chk("control", rd, 32'h0001_0028);
		for (int k = 0; k < 5; k++) begin
			bus(1, 9'h108, {24'h00_0000, rise_set[k]}, 4'hf);
			bus(1, 9'h110, {24'h00_0000, fall_set[k]}, 4'hf);
			bus(0, 9'h108, 32'h0000_0000, 4'hf);
			chk("rise setting", rd, {24'h00_0000, rise_set[k]});
			bus(0, 9'h110, 32'h0000_0000, 4'hf);
			chk("fall setting", rd, {24'h00_0000, fall_set[k]});
			repeat (60) @(posedge clk_in);
			@(negedge first_out);
			repeat (2) @(posedge clk_in);
			bus(0, 9'h144, 32'h0000_0000, 4'hf);
			chk("high", 32'(ff - fr), 32'(exp_hi[k]));
			chk("rise gap", 32'(fr - sr), 32'(exp_gap[k]));
			$display("edge case %0d done", k);
		end
		bus(1, 9'h140, 32'h0000_0028, 4'hf);
		repeat (5) @(posedge clk_in);
		chk("stopped", 32'({first_out, second_out}), 32'h0000_0000);
		$display("stop test done");
		close_out();
	end
endmodule
